// ===== pss_top.sv
// Purpose: low power states and cold start of the power control state machine
// Assumes: analog comparators deliver levels; pins pass a two-flop synchroniser
// Notes:   reset outputs are open drain: oe high pulls the line low
// Contract
// - serial-bus control accepted only in watchdog, on and user off wait.
// - interrupt line held low outside watchdog and on.
// - enter coin-cell state on low battery without a power cut.
// - coin-cell rejects turn-on; exits to off once battery above undervoltage level.
// - both reset outputs low throughout coin-cell state.
// - backup supply below 0.9 V in coin-cell gives full logic reset; the logic only sets depleted, so defaults load at the next cold start.
// - after depletion, next turn-on restores every register bit default.
// - off is left only on a valid turn-on; the logic also leaves it for coin-cell on low battery without a power cut.
// - off ignores turn-on while battery below undervoltage level.
// - off keeps regulators disabled; only core logic and timekeeping powered.
// - no state timer runs in off.
// - both reset outputs low while in off.
// - cold start on turn-on, warm boot, power-cut recovery or silent restart.
// - first 8.0 ms of cold start is initialization, mode pins latched.
// - regulators enabled one after another after initialization.
// - both reset outputs low during cold start.
// - reset timer starts on entering cold start.
// - on reset timer expiry go to watchdog, release open-drain resets.
// - cold start ignores keep-alive and standby inputs.
// - watchdog timer runs in watchdog; expiry moves to on, keep-alive watched.
`timescale 1ns/100ps
`default_nettype none
module pss_top
	import pss_pkg::*;
#(
	parameter int unsigned INIT_COUNT  = INIT_CYCLES,
	parameter int unsigned RESET_COUNT = RESET_CYCLES,
	parameter int unsigned WDOG_COUNT  = WDOG_CYCLES,
	parameter int unsigned SLOT_COUNT  = SLOT_CYCLES
) (
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	input  wire logic                      battery_above_uv,
	input  wire logic                      backup_depleted,
	input  wire logic                      supply_interruption,
	input  wire logic                      turn_on_event,
	input  wire logic                      warm_boot_req,
	input  wire logic                      power_cut_recovered,
	input  wire logic                      silent_restart_req,
	input  wire logic                      watchdog_keepalive_input,
	input  wire logic                      standby_input,
	input  wire logic [POWER_UP_MODE_SELECT_W-1:0]         power_up_mode_select,
	input  wire logic                      user_off_wait_active,
	input  wire logic                      irq_pending,
	output var  logic                      irq_out,
	output var  logic                      bus_access_enable,
	output var  logic                      register_defaults_load,
	output var  logic                      core_logic_supply_en,
	output var  logic [NUM_REGULATORS-1:0] regulator_en,
	output var  logic [POWER_UP_MODE_SELECT_W-1:0]         latched_mode_select,
	output var  logic                      system_reset_out_n_oe,
	output var  logic                      processor_reset_out_n_oe,
	output var  logic                      keepalive_monitor_en,
	output var  logic                      keepalive_lost,
	output var  logic                      standby_seen,
	output var  logic [2:0]                power_state
);
	localparam int unsigned NIN = 9 + POWER_UP_MODE_SELECT_W;
	// edges until synchronised pin levels can be trusted after reset
	localparam logic [1:0]  SETTLE_DONE = 2'h2;

	logic [NIN-1:0]     pins_raw;
	logic [NIN-1:0]     pins;
	logic               s_batt_ok;
	logic               s_deplete;
	logic               s_supply_interruption;
	logic               s_turn_on;
	logic               s_warm;
	logic               s_supply_interruption_ok;
	logic               s_silent;
	logic               s_keep;
	logic               s_stby;
	logic [POWER_UP_MODE_SELECT_W-1:0]  s_power_up_mode_select;

	pss_state_t         state;
	pss_state_t         next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [TIMER_W-1:0] rst_timer;
	logic [TIMER_W-1:0] next_rst_timer;
	logic               init_done;
	logic               next_init_done;
	logic               depleted;
	logic               next_depleted;
	logic               defaults;
	logic               next_defaults;
	logic [POWER_UP_MODE_SELECT_W-1:0]  next_power_up_mode_select;
	logic               next_irq;
	logic               next_bus;
	logic               next_core;
	logic               next_sys_oe;
	logic               next_proc_oe;
	logic               next_ka_en;
	logic               next_ka_lost;
	logic               next_stby_seen;
	logic               cold_entry;
	logic [1:0]         settle;
	logic [1:0]         next_settle;

	pss_seq_if #(.N(NUM_REGULATORS)) sq ();

	assign pins_raw = {power_up_mode_select, standby_input, watchdog_keepalive_input,
		silent_restart_req, power_cut_recovered, warm_boot_req, turn_on_event,
		supply_interruption, backup_depleted, battery_above_uv};

	// every pin input except irq_pending and user_off_wait_active passes two flops before any logic reads it
	pss_sync #(.W(NIN)) u_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in (pins_raw),
		.sync_out (pins)
	);

	// synchronised pin fields
	assign s_batt_ok = pins[0];
	assign s_deplete = pins[1];
	assign s_supply_interruption    = pins[2];
	assign s_turn_on = pins[3];
	assign s_warm    = pins[4];
	assign s_supply_interruption_ok = pins[5];
	assign s_silent  = pins[6];
	assign s_keep    = pins[7];
	assign s_stby    = pins[8];
	assign s_power_up_mode_select    = pins[NIN-1:9];

	pss_reg_seq #(.N(NUM_REGULATORS), .SLOT_COUNT(SLOT_COUNT)) u_seq (
		.clk_sys (clk_sys),
		.srst    (srst),
		.sq      (sq)
	);

	// synchroniser reset zeros are not real pin levels: hold state until flushed
	always_comb begin
		next_settle = settle;
		if (settle != SETTLE_DONE) begin
			next_settle = settle + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			settle <= 2'h0;
		end else begin
			settle <= next_settle;
		end
	end

	assign cold_entry   = (state != PSS_COLD) && (next_state == PSS_COLD);
	// supplies drop at once on the way into off or coin-cell
	assign sq.clear     = (next_state == PSS_OFF) || (next_state == PSS_BACKUP);
	// start pulse on the last initialization cycle
	assign sq.start     = (state == PSS_COLD) && !init_done &&
		(timer == TIMER_W'(INIT_COUNT - 1));
	assign regulator_en = sq.enables;
	assign power_state  = state;

	always_comb begin
		next_state     = state;
		next_timer     = timer;
		next_rst_timer = rst_timer;
		next_init_done = init_done;
		next_depleted  = depleted;
		next_defaults  = 1'b0;
		next_power_up_mode_select      = latched_mode_select;
		next_ka_lost   = 1'b0;
		next_stby_seen = 1'b0;
		unique case (state)
			PSS_BACKUP: begin
				next_timer = '0;
				if (s_deplete) begin
					next_depleted = 1'b1;
				end
				if (s_batt_ok) begin
					next_state = PSS_OFF;
				end
			end
			PSS_OFF: begin
				next_timer = '0;
				if (!s_batt_ok && !s_supply_interruption) begin
					next_state = PSS_BACKUP;
				end else if (s_turn_on && s_batt_ok) begin
					next_state = PSS_COLD;
				end
			end
			PSS_COLD: begin
				// keep-alive and standby are not looked at here
				if (!init_done) begin
					if (timer == TIMER_W'(INIT_COUNT - 1)) begin
						next_init_done = 1'b1;
						next_power_up_mode_select      = s_power_up_mode_select;
						next_timer     = '0;
					end else begin
						next_timer = timer + TIMER_W'(1);
					end
				end
				// reset timer runs apart from init; a short one cuts init
				if (rst_timer == TIMER_W'(RESET_COUNT - 1)) begin
					next_state = PSS_WATCHDOG;
					next_timer = '0;
				end else begin
					next_rst_timer = rst_timer + TIMER_W'(1);
				end
			end
			PSS_WATCHDOG: begin
				if (timer == TIMER_W'(WDOG_COUNT - 1)) begin
					next_state = PSS_ON;
					next_timer = '0;
				end else begin
					next_timer = timer + TIMER_W'(1);
				end
			end
			PSS_ON: begin
				next_ka_lost   = !s_keep;
				next_stby_seen = s_stby;
				if (s_silent || s_warm || s_supply_interruption_ok) begin
					next_state = PSS_COLD;
				end
			end
			PSS_EXTERNAL: begin
				if (s_warm || s_supply_interruption_ok || s_silent) begin
					next_state = PSS_COLD;
				end
			end
			default: begin
				next_state = PSS_OFF;
			end
		endcase
		// battery loss without a power cut overrides every state
		if (!s_batt_ok && !s_supply_interruption && state != PSS_BACKUP) begin
			next_state = PSS_BACKUP;
		end
		// pins still hold the synchroniser's reset zeros
		if (settle != SETTLE_DONE) begin
			next_state = state;
		end
		// pin reports only while staying in on
		if (next_state != PSS_ON) begin
			next_ka_lost   = 1'b0;
			next_stby_seen = 1'b0;
		end
		if (next_state == PSS_COLD && state != PSS_COLD) begin
			next_rst_timer = '0;
			next_timer     = '0;
			next_init_done = 1'b0;
			// defaults reload only after a depletion or after srst, which also sets depleted
			if (depleted) begin
				next_defaults = 1'b1;
				next_depleted = 1'b0;
			end
		end
		// outputs follow the state being entered
		next_irq     = irq_pending &&
			(next_state == PSS_WATCHDOG || next_state == PSS_ON);
		next_bus     = (next_state == PSS_WATCHDOG) || (next_state == PSS_ON) ||
			(next_state == PSS_EXTERNAL && user_off_wait_active);
		next_core    = (next_state != PSS_BACKUP);
		next_sys_oe  = !(next_state == PSS_WATCHDOG || next_state == PSS_ON);
		next_proc_oe = !(next_state == PSS_WATCHDOG || next_state == PSS_ON);
		next_ka_en   = (next_state == PSS_ON);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state                    <= PSS_OFF;
			timer                    <= '0;
			rst_timer                <= '0;
			init_done                <= 1'b0;
			depleted                 <= 1'b1;
			register_defaults_load   <= 1'b0;
			latched_mode_select      <= POWER_UP_MODE_SELECT_RESET;
			irq_out                  <= 1'b0;
			bus_access_enable        <= 1'b0;
			core_logic_supply_en     <= 1'b1;
			system_reset_out_n_oe    <= 1'b1;
			processor_reset_out_n_oe <= 1'b1;
			keepalive_monitor_en     <= 1'b0;
			keepalive_lost           <= 1'b0;
			standby_seen             <= 1'b0;
		end else begin
			state                    <= next_state;
			timer                    <= next_timer;
			rst_timer                <= next_rst_timer;
			init_done                <= next_init_done;
			depleted                 <= next_depleted;
			register_defaults_load   <= next_defaults;
			latched_mode_select      <= next_power_up_mode_select;
			irq_out                  <= next_irq;
			bus_access_enable        <= next_bus;
			core_logic_supply_en     <= next_core;
			system_reset_out_n_oe    <= next_sys_oe;
			processor_reset_out_n_oe <= next_proc_oe;
			keepalive_monitor_en     <= next_ka_en;
			keepalive_lost           <= next_ka_lost;
			standby_seen             <= next_stby_seen;
		end
	end
endmodule
`default_nettype wire

// ===== pss_pkg.sv
// Purpose: shared constants and types for the power state sequencer
// Assumes: 10 MHz system clock
// Notes:   times are held in their own unit and converted to cycles here
package pss_pkg;
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned INIT_TIME_US     = 8000;
	localparam int unsigned INIT_CYCLES      = (INIT_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned RESET_TIME_US    = 20000;
	localparam int unsigned RESET_CYCLES     = (RESET_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned WDOG_TIME_US     = 128000;
	localparam int unsigned WDOG_CYCLES      = (WDOG_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned SLOT_TIME_US     = 2000;
	localparam int unsigned SLOT_CYCLES      = (SLOT_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned NUM_REGULATORS   = 8;
	localparam int unsigned TIMER_W          = 24;
	localparam int unsigned POWER_UP_MODE_SELECT_W           = 4;
	localparam logic [NUM_REGULATORS-1:0] REG_EN_RESET = 8'h00;
	localparam logic [POWER_UP_MODE_SELECT_W-1:0]         POWER_UP_MODE_SELECT_RESET   = 4'h0;

	// gray codes along backup -> off -> cold -> watchdog -> on
	typedef enum logic [2:0] {
		PSS_BACKUP   = 3'b000,
		PSS_OFF      = 3'b001,
		PSS_COLD     = 3'b011,
		PSS_WATCHDOG = 3'b010,
		PSS_ON       = 3'b110,
		PSS_EXTERNAL = 3'b111
	} pss_state_t;
endpackage

// ===== pss_seq_if.sv
// Purpose: carries regulator sequencing handshake between top and sequencer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, done a level
`timescale 1ns/100ps
`default_nettype none
interface pss_seq_if #(parameter int unsigned N = 8);
	logic         start;
	logic         clear;
	logic         done;
	logic [N-1:0] enables;
	modport ctrl (output start, output clear, input done, input enables);
	modport seq  (input start, input clear, output done, output enables);
endinterface
`default_nettype wire

// ===== pss_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination clock clk_sys
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
`default_nettype none
module pss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync_out;

	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

// ===== pss_reg_seq.sv
// Purpose: enables regulators one at a time, one slot apart
// Assumes: start pulse on the last initialization cycle
// Notes:   clear drops all enables at once
`timescale 1ns/100ps
`default_nettype none
module pss_reg_seq
	import pss_pkg::*;
#(
	parameter int unsigned N          = NUM_REGULATORS,
	parameter int unsigned SLOT_COUNT = SLOT_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	pss_seq_if.seq    sq
);
	logic [N-1:0]       en;
	logic [N-1:0]       next_en;
	logic [TIMER_W-1:0] slot;
	logic [TIMER_W-1:0] next_slot;
	logic               run;
	logic               next_run;

	assign sq.enables = en;
	assign sq.done    = &en;

	always_comb begin
		next_en   = en;
		next_slot = slot;
		next_run  = run;
		if (sq.clear) begin
			next_en   = '0;
			next_slot = '0;
			next_run  = 1'b0;
		end else if (sq.start) begin
			next_run  = 1'b1;
			next_slot = '0;
		end else if (run && !(&en)) begin
			// one more supply per slot limits inrush
			if (slot == TIMER_W'(SLOT_COUNT - 1)) begin
				next_slot = '0;
				next_en   = {en[N-2:0], 1'b1};
			end else begin
				next_slot = slot + TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			en   <= REG_EN_RESET;
			slot <= '0;
			run  <= 1'b0;
		end else begin
			en   <= next_en;
			slot <= next_slot;
			run  <= next_run;
		end
	end
endmodule
`default_nettype wire

// ===== pss_top_asserts.sv
// Purpose: state gating and timing checks on pss_top ports
// Assumes: one clock domain, sync reset
// Notes:   timer bounds allow two cycles of slack
`timescale 1ns/100ps
`default_nettype none
module pss_top_asserts
	import pss_pkg::*;
#(
	parameter int unsigned RESET_COUNT = RESET_CYCLES,
	parameter int unsigned WDOG_COUNT  = WDOG_CYCLES
) (
	input wire logic                      clk_sys,
	input wire logic                      srst,
	input wire logic                      battery_above_uv,
	input wire logic                      supply_interruption,
	input wire logic                      irq_out,
	input wire logic                      bus_access_enable,
	input wire logic                      register_defaults_load,
	input wire logic                      core_logic_supply_en,
	input wire logic [NUM_REGULATORS-1:0] regulator_en,
	input wire logic [POWER_UP_MODE_SELECT_W-1:0]         latched_mode_select,
	input wire logic                      system_reset_out_n_oe,
	input wire logic                      processor_reset_out_n_oe,
	input wire logic                      keepalive_lost,
	input wire logic                      standby_seen,
	input wire logic [2:0]                power_state
);
	localparam logic [TIMER_W-1:0] R_LO = TIMER_W'(RESET_COUNT - 2);
	localparam logic [TIMER_W-1:0] R_HI = TIMER_W'(RESET_COUNT + 2);
	localparam logic [TIMER_W-1:0] W_LO = TIMER_W'(WDOG_COUNT - 2);
	localparam logic [TIMER_W-1:0] W_HI = TIMER_W'(WDOG_COUNT + 2);
	logic [TIMER_W-1:0] cold_cnt;
	logic [TIMER_W-1:0] wd_cnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// cycles spent so far in the current cold start and watchdog stay
	always_ff @(posedge clk_sys) begin
		if (srst || power_state != PSS_COLD) begin
			cold_cnt <= '0;
		end else begin
			cold_cnt <= cold_cnt + TIMER_W'(1);
		end
		if (srst || power_state != PSS_WATCHDOG) begin
			wd_cnt <= '0;
		end else begin
			wd_cnt <= wd_cnt + TIMER_W'(1);
		end
	end
	property p_irq; irq_out |-> power_state inside {PSS_WATCHDOG, PSS_ON}; endproperty
	a_irq: assert property (p_irq) else $error("irq outside watchdog and on");
	property p_bus; bus_access_enable |-> power_state inside {PSS_WATCHDOG, PSS_ON, PSS_EXTERNAL}; endproperty
	a_bus: assert property (p_bus) else $error("bus open in wrong state");
	property p_rst; power_state inside {PSS_BACKUP, PSS_OFF, PSS_COLD}
		|-> system_reset_out_n_oe && processor_reset_out_n_oe; endproperty
	a_rst: assert property (p_rst) else $error("reset released early");
	property p_off; power_state == PSS_OFF |-> regulator_en == '0 && core_logic_supply_en; endproperty
	a_off: assert property (p_off) else $error("supplies wrong in off");
	property p_step; $changed(regulator_en) && regulator_en != '0 && $past(power_state) == PSS_COLD
		|-> regulator_en == (($past(regulator_en) << 1) | 8'h01); endproperty
	a_step: assert property (p_step) else $error("regulators not one by one");
	property p_wdog; power_state == PSS_COLD |-> cold_cnt < R_HI; endproperty
	a_wdog: assert property (p_wdog) else $error("cold start lasts too long");
	property p_wdlen; power_state == PSS_WATCHDOG && $past(power_state) == PSS_COLD
		|-> cold_cnt >= R_LO && cold_cnt <= R_HI; endproperty
	a_wdlen: assert property (p_wdlen) else $error("reset timer length wrong");
	property p_on; power_state == PSS_WATCHDOG |-> wd_cnt < W_HI; endproperty
	a_on: assert property (p_on) else $error("watchdog stay lasts too long");
	property p_onlen; power_state == PSS_ON && $past(power_state) == PSS_WATCHDOG
		|-> wd_cnt >= W_LO && wd_cnt <= W_HI; endproperty
	a_onlen: assert property (p_onlen) else $error("watchdog timer length wrong");
	property p_bkin; !battery_above_uv && !supply_interruption |-> ##[1:5] power_state == PSS_BACKUP;
	endproperty
	a_bkin: assert property (p_bkin) else $error("backup not entered");
	property p_bkout; power_state == PSS_BACKUP |=> power_state inside {PSS_BACKUP, PSS_OFF}; endproperty
	a_bkout: assert property (p_bkout) else $error("bad exit from backup");
	property p_offx; power_state == PSS_OFF |=> power_state inside {PSS_OFF, PSS_COLD, PSS_BACKUP};
	endproperty
	a_offx: assert property (p_offx) else $error("bad exit from off");
	property p_dflt; register_defaults_load |-> power_state == PSS_COLD ##1 !register_defaults_load;
	endproperty
	a_dflt: assert property (p_dflt) else $error("defaults pulse wrong");
	property p_ka; keepalive_lost || standby_seen |-> power_state == PSS_ON; endproperty
	a_ka: assert property (p_ka) else $error("pins heeded outside on");
	property p_latch; $changed(latched_mode_select) |-> power_state == PSS_COLD; endproperty
	a_latch: assert property (p_latch) else $error("mode pins latched outside cold");
endmodule
`default_nettype wire

// ===== pss_ap_model.sv
// Purpose: processor side: pull-ups on reset lines, keep-alive source
// Assumes: open-drain resets, oe high pulls low
// Notes:   keep-alive held only while processor is out of reset
`timescale 1ns/100ps
`default_nettype none
module pss_ap_model (
	input  wire logic clk_sys,
	input  wire logic system_reset_out_n_oe,
	input  wire logic processor_reset_out_n_oe,
	output wire logic system_reset_out_n,
	output wire logic processor_reset_out_n,
	output var  logic watchdog_keepalive_input
);
	assign system_reset_out_n    = system_reset_out_n_oe ? 1'b0 : 1'b1;
	assign processor_reset_out_n = processor_reset_out_n_oe ? 1'b0 : 1'b1;
	always @(negedge clk_sys) begin
		watchdog_keepalive_input <= system_reset_out_n & processor_reset_out_n;
	end
endmodule
`default_nettype wire

// ===== pss_top_tb_top.sv
// Purpose: self-checking bench for pss_top
// Assumes: shortened counts via parameters
// Notes:   inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module pss_top_tb_top;
	import pss_pkg::*;
	localparam int unsigned RC = 200;
	localparam int unsigned WC = 50;
	logic       clk_sys, srst, battery_above_uv, backup_depleted, supply_interruption;
	logic       turn_on_event, warm_boot_req, power_cut_recovered, silent_restart_req;
	logic       standby_input, user_off_wait_active, irq_pending, irq_out, bus_access_enable;
	logic       register_defaults_load, core_logic_supply_en, system_reset_out_n_oe;
	logic       processor_reset_out_n_oe, keepalive_monitor_en, keepalive_lost, standby_seen;
	logic [3:0] power_up_mode_select, latched_mode_select;
	logic [7:0] regulator_en;
	logic [2:0] power_state;
	wire        system_reset_out_n, processor_reset_out_n, watchdog_keepalive_input;
	int         n_errors = 0;
	int         n_compared = 0;
	int         n_def = 0;
	pss_top #(.INIT_COUNT(20), .RESET_COUNT(RC), .WDOG_COUNT(WC), .SLOT_COUNT(10)) u_pss_top (.*);
	pss_ap_model u_pss_ap_model (.*);
	always @(posedge clk_sys) begin
		if (register_defaults_load === 1'b1) n_def++;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_st(input logic [2:0] st, output int n);
		n = 0;
		while (power_state !== st && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk(power_state, st);
	endtask
	task automatic t_reset();
		chk(power_state, PSS_OFF);
		chk({system_reset_out_n, processor_reset_out_n, irq_out, bus_access_enable}, 4'h0);
		chk({core_logic_supply_en, regulator_en}, 9'h100);
	endtask
	task automatic t_release();
		srst = 1'b1;
		repeat (6) @(negedge clk_sys);
		srst = 1'b0;
		repeat (4) begin
			@(negedge clk_sys);
			chk({power_state, core_logic_supply_en}, {PSS_OFF, 1'b1});
		end
		t_reset();
	endtask
	task automatic t_low();
		int n;
		supply_interruption = 1'b1;
		battery_above_uv = 1'b0;
		turn_on_event = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk(power_state, PSS_OFF);
		turn_on_event = 1'b0;
		supply_interruption = 1'b0;
		wait_st(PSS_BACKUP, n);
		chk({system_reset_out_n, processor_reset_out_n, core_logic_supply_en}, 3'h0);
		turn_on_event = 1'b1;
		backup_depleted = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk(power_state, PSS_BACKUP);
		turn_on_event = 1'b0;
		backup_depleted = 1'b0;
		battery_above_uv = 1'b1;
		wait_st(PSS_OFF, n);
		repeat (10) @(negedge clk_sys);
		chk(power_state, PSS_OFF);
	endtask
	task automatic t_cold(input int cause, input logic dflt);
		int n;
		n_def = 0;
		case (cause)
			0: turn_on_event = 1'b1;
			1: warm_boot_req = 1'b1;
			2: power_cut_recovered = 1'b1;
			default: silent_restart_req = 1'b1;
		endcase
		wait_st(PSS_COLD, n);
		{turn_on_event, warm_boot_req, power_cut_recovered, silent_restart_req} = 4'h0;
		standby_input = 1'b1;
		chk({irq_out, bus_access_enable, system_reset_out_n, processor_reset_out_n}, 4'h0);
		wait_st(PSS_WATCHDOG, n);
		chk(n >= RC - 2 && n <= RC + 1, 1'b1);
		chk(n_def, dflt);
		chk(regulator_en, 8'hFF);
		chk(latched_mode_select, 4'hA);
		chk(standby_seen, 1'b0);
		chk({irq_out, bus_access_enable, system_reset_out_n, processor_reset_out_n}, 4'hF);
		wait_st(PSS_ON, n);
		chk(n >= WC - 2 && n <= WC + 1, 1'b1);
		repeat (3) @(negedge clk_sys);
		chk({keepalive_monitor_en, standby_seen, keepalive_lost}, 3'h6);
		standby_input = 1'b0;
	endtask
	task automatic t_deplete(input logic dep);
		int n;
		battery_above_uv = 1'b0;
		wait_st(PSS_BACKUP, n);
		chk({system_reset_out_n, processor_reset_out_n, irq_out, bus_access_enable}, 4'h0);
		backup_depleted = dep;
		repeat (5) @(negedge clk_sys);
		backup_depleted = 1'b0;
		battery_above_uv = 1'b1;
		wait_st(PSS_OFF, n);
		chk(regulator_en, 8'h00);
		t_cold(0, dep);
	endtask
	task automatic wrap_up();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		n_errors++;
		wrap_up();
	end
	initial begin
		battery_above_uv = 1'b1;
		{backup_depleted, supply_interruption, turn_on_event, warm_boot_req} = 4'h0;
		{power_cut_recovered, silent_restart_req, standby_input} = 3'h0;
		user_off_wait_active = 1'b1;
		irq_pending = 1'b1;
		power_up_mode_select = 4'hA;
		t_release();
		t_low();
		for (int i = 0; i < 4; i++) t_cold(i, i == 0);
		t_deplete(1'b0);
		t_deplete(1'b1);
		t_release();
		wrap_up();
	end
endmodule
bind pss_top pss_top_asserts #(.RESET_COUNT(RESET_COUNT), .WDOG_COUNT(WDOG_COUNT)) u_pss_top_asserts (.*);
`default_nettype wire
